// ---- rtl/secl_pkg.sv ----
// constants for the serial nvm configuration loader
// assumes one 250 MHz system clock and a three-wire serial nvm part outside
package secl_pkg;
	localparam int SECL_CLK_DIV = 256;
	localparam int SECL_HALF_DIV = SECL_CLK_DIV / 2;
	localparam int SECL_WORDS = 8;
	localparam int SECL_WORD_W = 16;
	localparam int SECL_ADDR_W = 6;
	localparam int SECL_CMD_W = 1 + 2 + SECL_ADDR_W;
	localparam logic [1:0] SECL_OP_READ = 2'h2;
	localparam int SECL_SENSE_CYC = 16;
	// default identifier values are arbitrary
	localparam logic [15:0] SECL_DEF_WORD0 = 16'h1234;
	localparam logic [15:0] SECL_DEF_WORD1 = 16'h5678;
	localparam logic [15:0] SECL_DEF_OTHER = 16'h0000;
	// manual control register bit positions
	localparam int SECL_MAN_CLK_BIT = 0;
	localparam int SECL_MAN_CS_BIT = 1;
	localparam int SECL_MAN_WD_BIT = 2;
	localparam int SECL_MAN_RD_BIT = 3;
	localparam logic [3:0] SECL_MAN_RESET = 4'h0;
	typedef enum logic [2:0] {SECL_SENSE, SECL_CMD, SECL_DATA, SECL_GAP, SECL_DONE} secl_state_t;
endpackage

// ---- rtl/secl_cfg_mem.sv ----
// small register memory holding the loadable configuration words
// assumes one writer; read data is registered
`timescale 1ns/1ps
`default_nettype none
module secl_cfg_mem #(
	parameter int WORDS = 8,
	parameter int WIDTH = 16
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [$clog2(WORDS)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [$clog2(WORDS)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	import secl_pkg::*;
	logic [WIDTH-1:0] mem_q [WORDS];
	function automatic logic [WIDTH-1:0] def_word(input int idx);
		if (idx == 0)
			return WIDTH'(SECL_DEF_WORD0);
		else if (idx == 1)
			return WIDTH'(SECL_DEF_WORD1);
		return WIDTH'(SECL_DEF_OTHER);
	endfunction
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < WORDS; i++)
				mem_q[i] <= def_word(i);
			rd_data <= '0;
		end else if (clk_en) begin
			if (wr_en)
				mem_q[wr_addr] <= wr_data;
			rd_data <= mem_q[rd_addr];
		end
	end
endmodule
`default_nettype wire

// ---- rtl/secl_loader.sv ----
// serial nvm configuration loader: automatic fetch after reset, then manual access
// assumes all inputs synchronous to clk_sys and an external pull-up on chip select
`timescale 1ns/1ps
`default_nettype none
module secl_loader #(
	parameter int WORDS = secl_pkg::SECL_WORDS,
	parameter int WORD_W = secl_pkg::SECL_WORD_W
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic manual_wr,
	input wire logic [3:0] manual_wdata,
	output logic [3:0] manual_nvm_control_reg,
	output logic nvm_serial_clock,
	output logic nvm_chip_select,
	output logic nvm_chip_select_oe,
	input wire logic nvm_chip_select_in,
	output logic nvm_write_data,
	input wire logic nvm_read_data,
	output logic load_busy,
	output logic load_done,
	output logic nvm_present,
	input wire logic [$clog2(WORDS)-1:0] cfg_rd_addr,
	output logic [WORD_W-1:0] cfg_rd_data
);
	import secl_pkg::*;
	localparam int AW = $clog2(WORDS);
	secl_state_t state_q, state_d;
	logic [7:0] div_q;
	logic sclk_q;
	logic [4:0] bit_q;
	logic [AW-1:0] word_q;
	logic [WORD_W-1:0] shift_q;
	logic [SECL_CMD_W-1:0] cmd_q;
	logic [4:0] sense_q;
	logic present_q;
	logic [2:0] man_q;
	logic rd_q;
	logic cs_q;
	logic wd_q;
	logic mem_wr_q;
	function automatic logic [SECL_CMD_W-1:0] read_cmd(input logic [AW-1:0] w);
		return {1'b1, SECL_OP_READ, SECL_ADDR_W'(w)};
	endfunction

	wire auto_active = (state_q != SECL_DONE);
	wire sense_phase = (state_q == SECL_SENSE);
	wire div_wrap = (div_q == 8'(SECL_HALF_DIV - 1));
	// one rising and one falling serial clock edge per 256 system clocks
	wire sclk_rise = div_wrap && !sclk_q && !sense_phase;
	wire sclk_fall = div_wrap && sclk_q;
	wire last_cmd_bit = (bit_q == 5'(SECL_CMD_W - 1));
	wire last_data_bit = (bit_q == 5'(WORD_W - 1));
	wire last_word = (word_q == AW'(WORDS - 1));
	wire cmd_fall = (state_q == SECL_CMD) && sclk_fall;
	wire data_rise = (state_q == SECL_DATA) && sclk_rise;
	wire data_fall = (state_q == SECL_DATA) && sclk_fall;
	wire gap_fall = (state_q == SECL_GAP) && sclk_fall;
	wire word_end = data_fall && last_data_bit;
	wire first_cmd = sense_phase && (state_d == SECL_CMD);
	wire load_cmd = first_cmd || gap_fall;
	wire [AW-1:0] next_word = sense_phase ? word_q : word_q + AW'(1);
	wire [SECL_CMD_W-1:0] next_cmd = read_cmd(next_word);
	wire man_take = manual_wr && !auto_active;

	always_comb begin
		state_d = state_q;
		case (state_q)
			SECL_SENSE: begin
				if (sense_q == 5'(SECL_SENSE_CYC))
					state_d = nvm_chip_select_in ? SECL_CMD : SECL_DONE;
			end
			SECL_CMD: begin
				if (sclk_fall && last_cmd_bit)
					state_d = SECL_DATA;
			end
			SECL_DATA: begin
				if (sclk_fall && last_data_bit)
					state_d = last_word ? SECL_DONE : SECL_GAP;
			end
			SECL_GAP: begin
				if (sclk_fall)
					state_d = SECL_CMD;
			end
			SECL_DONE: state_d = SECL_DONE;
			default: state_d = SECL_DONE;
		endcase
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			state_q <= SECL_SENSE;
		else if (clk_en)
			state_q <= state_d;
	end

	// the divider rests at zero after the fetch so manual access sees no stray edges
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			div_q <= '0;
		else if (clk_en)
			div_q <= (div_wrap || !auto_active) ? 8'h00 : div_q + 8'h01;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			sclk_q <= 1'b0;
		else if (clk_en && (sclk_rise || sclk_fall))
			sclk_q <= ~sclk_q;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sense_q <= '0;
			present_q <= 1'b0;
		end else if (clk_en && sense_phase) begin
			sense_q <= sense_q + 5'h01;
			present_q <= nvm_chip_select_in;
		end
	end

	// one counter serves both phases; it restarts at every phase boundary
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			bit_q <= '0;
		else if (clk_en) begin
			if (load_cmd)
				bit_q <= '0;
			else if (cmd_fall)
				bit_q <= last_cmd_bit ? 5'h00 : bit_q + 5'h01;
			else if (data_fall)
				bit_q <= last_data_bit ? 5'h00 : bit_q + 5'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			word_q <= '0;
		else if (clk_en && gap_fall)
			word_q <= next_word;
	end

	// the start bit leaves at load time, so the first rising edge already carries it
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			cmd_q <= '0;
		else if (clk_en) begin
			if (load_cmd)
				cmd_q <= {next_cmd[SECL_CMD_W-2:0], 1'b0};
			else if (cmd_fall)
				cmd_q <= {cmd_q[SECL_CMD_W-2:0], 1'b0};
		end
	end

	// command bits change on falling edges so the part sees them settled on rising edges
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			wd_q <= 1'b0;
		else if (clk_en) begin
			if (load_cmd)
				wd_q <= next_cmd[SECL_CMD_W-1];
			else if (cmd_fall)
				wd_q <= cmd_q[SECL_CMD_W-1];
			else if (data_fall)
				wd_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			shift_q <= '0;
		else if (clk_en && data_rise)
			shift_q <= {shift_q[WORD_W-2:0], nvm_read_data};
	end

	// chip select drops for one serial clock period between words
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			cs_q <= 1'b0;
		else if (clk_en) begin
			if (load_cmd)
				cs_q <= 1'b1;
			else if (word_end)
				cs_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			mem_wr_q <= 1'b0;
		else if (clk_en)
			mem_wr_q <= word_end;
	end

	// manual register: writes are ignored while the automatic fetch runs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			man_q <= SECL_MAN_RESET[2:0];
		else if (clk_en && man_take)
			man_q <= manual_wdata[2:0];
	end

	// bit 3 is read-only, so manual_wdata[3] is never stored
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			rd_q <= 1'b0;
		else if (clk_en)
			rd_q <= nvm_read_data;
	end

	secl_cfg_mem #(
		.WORDS(WORDS),
		.WIDTH(WORD_W)
	) u_mem (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.wr_en(mem_wr_q),
		.wr_addr(word_q),
		.wr_data(shift_q),
		.rd_addr(cfg_rd_addr),
		.rd_data(cfg_rd_data)
	);

	assign nvm_serial_clock = auto_active ? sclk_q : man_q[SECL_MAN_CLK_BIT];
	// chip select is released during sensing so the pull-up can be seen
	assign nvm_chip_select = auto_active ? cs_q : man_q[SECL_MAN_CS_BIT];
	assign nvm_chip_select_oe = !sense_phase;
	assign nvm_write_data = auto_active ? wd_q : man_q[SECL_MAN_WD_BIT];
	assign manual_nvm_control_reg = {rd_q, man_q};
	assign load_busy = auto_active;
	assign load_done = !auto_active;
	assign nvm_present = present_q;
endmodule
`default_nettype wire

// ---- tb/secl_monitor.sv ----
// port checker for the loader
// bound to every secl_loader instance
`timescale 1ns/1ps
`default_nettype none
module secl_monitor (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic manual_wr,
	input wire logic [3:0] manual_wdata,
	input wire logic [3:0] manual_nvm_control_reg,
	input wire logic nvm_serial_clock,
	input wire logic nvm_chip_select,
	input wire logic nvm_chip_select_oe,
	input wire logic nvm_write_data,
	input wire logic nvm_read_data,
	input wire logic load_busy,
	input wire logic load_done,
	input wire logic nvm_present
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic [7:0] run_q;
	logic ck_q;
	wire logic chg = ck_q != nvm_serial_clock;
	// run length saturates so long idle stretches never wrap
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			run_q <= 8'hff;
			ck_q <= 1'b0;
		end else begin
			ck_q <= nvm_serial_clock;
			run_q <= chg ? 8'h00 : run_q + {7'h00, run_q != 8'hff};
		end
	end
	sequence s_sense;
		!nvm_chip_select_oe [*8];
	endsequence
	a_sense_phase: assert property ($rose(reset_n) |=> s_sense)
		else $error("sense oe");
	a_cs_present: assert property (load_busy && nvm_chip_select |-> nvm_present)
		else $error("fetch without part");
	a_sclk_rate: assert property (load_busy && chg |-> run_q >= 8'h7f)
		else $error("auto clock fast");
	// refused writes during the fetch must leave chip select and serial clock idle at hand-over
	a_fetch_release: assert property ($fell(load_busy)
		|-> !nvm_chip_select && !nvm_serial_clock)
		else $error("pins not idle after fetch");
	a_manual_take: assert property (load_done && clk_en && manual_wr
		|=> manual_nvm_control_reg[2:0] == $past(manual_wdata[2:0]))
		else $error("manual write lost");
	a_pins_follow: assert property (load_done |-> manual_nvm_control_reg[2:0]
		== {nvm_write_data, nvm_chip_select, nvm_serial_clock})
		else $error("pins off reg");
	a_read_level: assert property (load_done && clk_en
		|=> manual_nvm_control_reg[3] == $past(nvm_read_data))
		else $error("read level");
	a_frozen: assert property (!clk_en |=> $stable(manual_nvm_control_reg))
		else $error("frozen reg moved");
endmodule
bind secl_loader secl_monitor mon_u (
	.clk_sys(clk_sys),
	.reset_n(reset_n),
	.clk_en(clk_en),
	.manual_wr(manual_wr),
	.manual_wdata(manual_wdata),
	.manual_nvm_control_reg(manual_nvm_control_reg),
	.nvm_serial_clock(nvm_serial_clock),
	.nvm_chip_select(nvm_chip_select),
	.nvm_chip_select_oe(nvm_chip_select_oe),
	.nvm_write_data(nvm_write_data),
	.nvm_read_data(nvm_read_data),
	.load_busy(load_busy),
	.load_done(load_done),
	.nvm_present(nvm_present)
);
`default_nettype wire

// ---- tb/secl_nvm_model.sv ----
// three-wire serial nvm model
// assumes the loader samples read data on rising clock
`timescale 1ns/1ps
`default_nettype none
module secl_nvm_model (
	input wire logic sclk,
	input wire logic cs,
	input wire logic din,
	output logic dout
);
	int n = 0;
	logic [8:0] cmd = 9'h000;
	wire logic [15:0] good = 16'h8001 ^ (16'h1111 * {10'h000, cmd[5:0]});
	// a wrong start bit or opcode answers with a word that no test expects
	wire logic [15:0] w = (cmd[8:6] == 3'h6) ? good : 16'h0bad;
	initial dout = 1'b0;
	always @(posedge sclk or negedge cs) begin
		if (!cs) n <= 0;
		else begin
			if (n < 9) cmd <= {cmd[7:0], din};
			n <= n + 1;
		end
	end
	// released line toggles so a stale bit is never mistaken for data
	always @(negedge sclk or negedge cs) begin
		if (cs && n >= 9 && n < 25) dout <= w[24 - n];
		else dout <= ~dout;
	end
endmodule
`default_nettype wire

// ---- tb/serial_eeprom_config_loader_tb.sv ----
// bench: fetch with part fitted, manual access, no part fitted
// assumes package, loader, model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_config_loader_tb;
	import secl_pkg::*;
	logic clk_sys = 0, reset_n = 0, clk_en = 1, mwr = 0, fit = 1, rdv = 0;
	logic [3:0] mwd = 4'h0, ctl;
	logic [2:0] ra = 3'h0;
	logic [15:0] rd;
	logic sck, cs, oe, wd, busy, done, pres, mdo;
	int errors = 0, n_compared = 0, cyc = 0;
	always #2 clk_sys = ~clk_sys;
	secl_loader dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
		.manual_wr(mwr), .manual_wdata(mwd), .manual_nvm_control_reg(ctl),
		.nvm_serial_clock(sck), .nvm_chip_select(cs), .nvm_chip_select_oe(oe),
		.nvm_chip_select_in(oe ? cs : fit), .nvm_write_data(wd),
		.nvm_read_data(fit ? mdo : rdv), .load_busy(busy), .load_done(done),
		.nvm_present(pres), .cfg_rd_addr(ra), .cfg_rd_data(rd));
	secl_nvm_model nvm_u (.sclk(sck), .cs(cs), .din(wd), .dout(mdo));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic boot(input logic f);
		@(posedge clk_sys);
		reset_n <= 0;
		fit <= f;
		repeat (20) @(posedge clk_sys);
		reset_n <= 1;
		repeat (2) @(posedge clk_sys);
		mwr <= 1;
		mwd <= 4'h7;
		@(posedge clk_sys);
		mwr <= 0;
		for (int i = 0; i < 56000 && done !== 1'b1; i++) @(posedge clk_sys);
		#1 chk("refused", 16'h0, ctl[2:0]);
		chk("done", 16'h1, done);
		chk("busy", 16'h0, busy);
	endtask
	task automatic mw(input logic [3:0] v, input logic [2:0] e);
		@(posedge clk_sys);
		mwr <= 1;
		mwd <= v;
		@(posedge clk_sys);
		mwr <= 0;
		@(posedge clk_sys);
		#1 chk("pins", {e, e}, {ctl[2:0], wd, cs, sck});
	endtask
	task automatic rw(input logic [2:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		ra <= a;
		repeat (2) @(posedge clk_sys);
		#1 chk("word", e, rd);
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 70000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		boot(1);
		chk("present", 16'h1, pres);
		for (int i = 0; i < 8; i++) rw(3'(i), 16'h8001 ^ (16'h1111 * 16'(i)));
		$display("fetch test done");
		for (int v = 0; v < 8; v++) mw(4'(v), 3'(v));
		@(posedge clk_sys);
		clk_en <= 0;
		mw(4'h2, 3'h7); // a frozen block keeps the old bits
		@(posedge clk_sys);
		clk_en <= 1;
		$display("manual test done");
		boot(0);
		chk("present", 16'h0, pres);
		rw(0, SECL_DEF_WORD0);
		rw(1, SECL_DEF_WORD1);
		rw(5, SECL_DEF_OTHER);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys);
			rdv <= v[0];
			repeat (3) @(posedge clk_sys);
			#1 chk("rdlvl", 16'(v), ctl[3]);
		end
		$display("absent test done");
		finish_test();
	end
endmodule
`default_nettype wire
